// ==== hw/buffered_bit_io_ports.sv ====
// Three buffered 16-bit bit-addressed ports, flag memory and AHB config
`include "bitio_map.svh"
module buffered_bit_io_ports (
  input logic clk,
  input logic sys_rst,
  input logic [`ADDR_W-1:0] bit_addr,
  input logic bit_write_strobe_n,
  input logic serial_write_bit,
  input logic [`NUM_PORTS*`PORT_BITS-1:0] port_in,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [`DATA_W-1:0] hwdata,
  input logic hready,
  output logic [`DATA_W-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic serial_read_bit,
  output logic serial_read_en,
  output logic [`NUM_PORTS*`PORT_BITS-1:0] port_out,
  output logic [`NUM_PORTS*`PORT_BITS-1:0] pin_oe,
  output logic [2*`NUM_PORTS-1:0] output_driver_enable
);
  bitio_pkg::top_state_t s_r, s_nxt;

  logic [`NUM_PORTS-1:0] base_address_match;
  logic [`NUM_PORTS-1:0] port_match_select;
  logic [`NUM_PORTS-1:0] rst_en_q;
  logic [2*`NUM_PORTS-1:0] oe_q;
  logic [2*`NUM_PORTS-1:0] blk_rd_sel;
  logic [`NUM_PORTS-1:0] blk_rd_bit;
  logic [`NUM_PORTS*`PORT_BITS-1:0] latch_q;
  logic valid;
  logic wr_pulse;
  logic flag_sel;
  logic [1:0] blk_num;
  logic [`FLAG_IDX_W-1:0] flag_idx;
  logic ahb_acc;
  logic off_ok;
  logic [`OFF_W-1:0] rd_off;
  logic [`DATA_W-1:0] rdata;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  function automatic logic [`OFF_W-1:0] cfg_off(input int i);
    return `OFF_W'(`OFF_CFG0 + `OFF_STEP * i);
  endfunction

  function automatic logic [`OFF_W-1:0] latch_off(input int i);
    return `OFF_W'(`OFF_LATCH0 + `OFF_STEP * i);
  endfunction

  // ------------------------------------------------------------
  // Port selection
  // ------------------------------------------------------------
  // Only one matching port may answer; two equal base addresses
  // silence all of them rather than fight on the read line
  assign valid = base_address_match == 3'h1 ||
    base_address_match == 3'h2 ||
    base_address_match == 3'h4; // see (R19)
  assign port_match_select = base_address_match & {`NUM_PORTS{valid}};

  // Strobe falls once per bit transfer; address and data share its
  // synchroniser depth, so they line up with the pulse
  assign wr_pulse = s_r.strb_s3 && !s_r.strb_s2;

  assign flag_sel = valid && !s_r.addr_s2[`A10_BIT]; // see (R14)
  assign blk_num = port_match_select[1] ? 2'h1 :
    (port_match_select[2] ? 2'h2 : 2'h0); // see (R15)
  assign flag_idx = {blk_num, s_r.addr_s2[`A9_BIT],
    s_r.addr_s2[`A11_BIT:0]}; // see (R16)

  // ------------------------------------------------------------
  // Ports
  // ------------------------------------------------------------
  for (genvar p = 0; p < `NUM_PORTS; p++) begin : g_port
    bit_io_port u_port (
      .clk(clk),
      .sys_rst(sys_rst),
      .bit_addr(s_r.addr_s2),
      .write_pulse(wr_pulse),
      .serial_write_bit(s_r.wbit_s2),
      .port_match_select(port_match_select[p]),
      .base_addr(s_r.cfg[p][`BASE_W-1:0]),
      .port_enable(s_r.cfg[p][`CFG_EN_BIT]),
      .input_only(s_r.cfg[p][`CFG_INONLY_BIT]),
      .pol_high(s_r.cfg[p][`CFG_POLH_BIT]),
      .pol_low(s_r.cfg[p][`CFG_POLL_BIT]),
      .port_in(s_r.in_s2[p*`PORT_BITS +: `PORT_BITS]),
      .base_address_match(base_address_match[p]),
      .block_read_sel(blk_rd_sel[2*p +: 2]),
      .block_read_bit(blk_rd_bit[p]),
      .latch_q(latch_q[p*`PORT_BITS +: `PORT_BITS]),
      .oe_q(oe_q[2*p +: 2]),
      .rst_en_q(rst_en_q[p]),
      .output_driver_enable(output_driver_enable[2*p +: 2]),
      .pin_oe(pin_oe[p*`PORT_BITS +: `PORT_BITS])
    );
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // Pins come from the bus' own timing and pass two flops first
    s_nxt.addr_s1 = bit_addr;
    s_nxt.addr_s2 = s_r.addr_s1;
    s_nxt.strb_s1 = bit_write_strobe_n;
    s_nxt.strb_s2 = s_r.strb_s1;
    s_nxt.strb_s3 = s_r.strb_s2;
    s_nxt.wbit_s1 = serial_write_bit;
    s_nxt.wbit_s2 = s_r.wbit_s1;
    s_nxt.in_s1 = port_in;
    s_nxt.in_s2 = s_r.in_s1;

    // Flag memory, one bit wide, no hardware meaning
    if (wr_pulse && flag_sel) begin
      s_nxt.flag[flag_idx] = s_r.wbit_s2; // see (R21) see (R13)
    end

    // Read line answers for flags or an addressed block only
    s_nxt.rd_en = valid && (flag_sel || blk_rd_sel != '0); // see (R19)
    if (flag_sel) begin
      s_nxt.rd_bit = s_r.flag[flag_idx]; // see (R21)
    end else begin
      s_nxt.rd_bit = |({blk_rd_bit[2], blk_rd_bit[2],
        blk_rd_bit[1], blk_rd_bit[1], blk_rd_bit[0],
        blk_rd_bit[0]} & blk_rd_sel); // see (R10)
    end

    // AHB-Lite slave, zero wait states
    ahb_acc = hsel && htrans[1] && hready;
    // Upper address bits must be zero so high aliases stay unmapped
    s_nxt.ph_wr = ahb_acc && hwrite && hsize == `HSIZE_WORD &&
      haddr[31:`OFF_W] == '0;
    s_nxt.ph_off = haddr[`OFF_W-1:0];
    for (int i = 0; i < `NUM_PORTS; i++) begin
      if (s_r.ph_wr && s_r.ph_off == cfg_off(i)) begin
        s_nxt.cfg[i] = hwdata[`CFG_W-1:0];
      end
    end

    // Read data built from the post-write copy so a read right
    // behind a write to the same word sees the new value
    off_ok = haddr[31:`OFF_W] == '0;
    rd_off = haddr[`OFF_W-1:0];
    rdata = '0;
    if (off_ok && rd_off == `OFF_STATUS) begin
      rdata = `DATA_W'({oe_q, rst_en_q});
    end
    for (int i = 0; i < `NUM_PORTS; i++) begin
      if (off_ok && rd_off == cfg_off(i)) begin
        rdata = `DATA_W'(s_nxt.cfg[i]);
      end
      if (off_ok && rd_off == latch_off(i)) begin
        rdata = `DATA_W'(latch_q[i*`PORT_BITS +: `PORT_BITS]);
      end
    end
    s_nxt.hrdata = (ahb_acc && !hwrite) ? rdata : '0;
    s_nxt.hreadyout = 1'b1;
    s_nxt.hresp = 1'b0;

    // Hardware reset also returns every port to its input state
    if (sys_rst) begin
      s_nxt = '0; // see (R04)
      s_nxt.strb_s1 = 1'b1;
      s_nxt.strb_s2 = 1'b1;
      s_nxt.strb_s3 = 1'b1;
      s_nxt.cfg = {`NUM_PORTS{`CFG_RESET}};
    end
  end

  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign hrdata = s_r.hrdata;
  assign hreadyout = s_r.hreadyout;
  assign hresp = s_r.hresp;
  assign serial_read_bit = s_r.rd_bit;
  assign serial_read_en = s_r.rd_en;
  // Latches always hold their value; pin_oe decides if it reaches a pin
  assign port_out = latch_q; // see (R12)

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_flag_roundtrip;
    logic [`FLAG_IDX_W-1:0] idx;
    logic v;
    @(posedge clk) disable iff (sys_rst)
    (wr_pulse && flag_sel, idx = flag_idx, v = s_r.wbit_s2)
      ##1 (flag_sel && flag_idx == idx && !wr_pulse)
      |=> serial_read_en && serial_read_bit == v;
  endproperty

  a_flag_roundtrip: assert property (p_flag_roundtrip) // see (R21)
    else $error("flag read did not return written bit");
  a_dup_no_read: assert property (@(posedge clk) disable iff (sys_rst) // see (R19)
    (base_address_match != '0 && !valid) |=> !serial_read_en)
    else $error("read driven with several ports matching");
  a_flag_read_en: assert property (@(posedge clk) disable iff (sys_rst) // see (R14)
    flag_sel |=> serial_read_en)
    else $error("flag select did not drive read line");
  a_flag_blocks: assert property (@(posedge clk) disable iff (sys_rst) // see (R15)
    (wr_pulse && flag_sel && port_match_select[0]) |=>
      s_r.flag[`FLAG_BITS-1:32] == $past(s_r.flag[`FLAG_BITS-1:32]))
    else $error("flag write leaked into another block");
  a_block_read: assert property (@(posedge clk) disable iff (sys_rst) // see (R10)
    (port_match_select[0] && s_r.addr_s2[`A10_BIT] &&
      !s_r.addr_s2[`A11_BIT]) |=> serial_read_en &&
      serial_read_bit == $past(s_r.in_s2[{1'b1,
        s_r.addr_s2[`BITSEL_MSB:0]}]))
    else $error("high block read picked wrong input");
  a_bus_ready: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |=> hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  c_flag_write: cover property (@(posedge clk) disable iff (sys_rst)
    wr_pulse && flag_sel && port_match_select[2]);
  c_dup_match: cover property (@(posedge clk) disable iff (sys_rst)
    base_address_match == 3'h5);
  c_block_write: cover property (@(posedge clk) disable iff (sys_rst)
    wr_pulse && blk_rd_sel[1] ##1 pin_oe[`PORT_BITS-1]);
endmodule

// ==== hw/bitio_map.svh ====
// Offsets, field positions and reset values of the bit I/O ports
// ------------------------------------------------------------------
// Notes on behaviour
// (R01) Writing displacement 00 stores the write bit in the reset-enable latch.
// (R02) Software port clear passes only while the reset-enable latch is one.
// (R03) Writing zero at displacement 1E requests a clear, gated by reset-enable.
// (R04) Hardware reset clears every port and the reset-enable latch.
// (R05) A port is input after clear, output once written, until next clear.
// (R06) Active block write select sets that block's output-enable flop.
// (R07) Each driver enable has selectable polarity, active high or low.
// (R08) Any port clear resets output enables until the port is written again.
// (R09) Input-only setting keeps the port's drivers disabled.
// (R10) On block read, low three address bits pick the input line.
// (R11) On block write, low three address bits pick the latch bit.
// (R12) Block drivers drive latched values only while block enable is active.
// (R13) A one-bit-wide user flag memory is readable and writable over the bus.
// (R14) Flags are selected by a base match with A10 low.
// (R15) Flags form three 32-bit blocks chosen by the matching port.
// (R16) A9 and A11 to A14 pick one of 32 flags in a block.
// (R17) A11 low picks the high block, A11 high the low block.
// (R18) Block write select is its read select while the strobe is low; the code gates it with the one-cycle write pulse after the strobe falls.
// (R19) Several ports matching at once select no port and drive no read data.
// (R20) A port responds when six address MSBs match its base and it is enabled.
// (R21) Flag writes store the write bit; flag reads return the stored bit.
// ------------------------------------------------------------------
`ifndef BITIO_MAP_SVH
`define BITIO_MAP_SVH
`define NUM_PORTS 3
`define PORT_BITS 16
`define BLOCK_BITS 8
`define ADDR_W 12
`define BASE_MSB 11
`define BASE_LSB 6
`define BASE_W 6
`define DISP_MSB 5
`define A9_BIT 5
`define A10_BIT 4
`define A11_BIT 3
`define BITSEL_MSB 2
`define DISP_RESET_EN 6'h00
`define DISP_CLEAR 6'h1e
`define FLAG_BITS 96
`define FLAG_IDX_W 7
`define DATA_W 32
`define OFF_W 8
`define OFF_CFG0 8'h00
`define OFF_STEP 8'h04
`define OFF_STATUS 8'h0c
`define OFF_LATCH0 8'h10
`define CFG_W 10
`define CFG_EN_BIT 6
`define CFG_INONLY_BIT 7
`define CFG_POLH_BIT 8
`define CFG_POLL_BIT 9
`define CFG_RESET 10'h000
`define HSIZE_WORD 3'h2
`endif

// ==== hw/bitio_pkg.sv ====
// State types of the bit I/O ports
`include "bitio_map.svh"
package bitio_pkg;
  typedef struct packed {
    logic [`PORT_BITS-1:0] latch;
    logic [1:0] oe;
    logic rst_en;
    logic [1:0] drv_en;
    logic [`PORT_BITS-1:0] pin_oe;
  } port_state_t;

  typedef struct packed {
    logic [`ADDR_W-1:0] addr_s1;
    logic [`ADDR_W-1:0] addr_s2;
    logic strb_s1;
    logic strb_s2;
    logic strb_s3;
    logic wbit_s1;
    logic wbit_s2;
    logic [`NUM_PORTS*`PORT_BITS-1:0] in_s1;
    logic [`NUM_PORTS*`PORT_BITS-1:0] in_s2;
    logic [`FLAG_BITS-1:0] flag;
    logic rd_bit;
    logic rd_en;
    logic [`NUM_PORTS-1:0][`CFG_W-1:0] cfg;
    logic ph_wr;
    logic [`OFF_W-1:0] ph_off;
    logic [`DATA_W-1:0] hrdata;
    logic hreadyout;
    logic hresp;
  } top_state_t;
endpackage

// ==== hw/bit_io_port.sv ====
// One 16-bit port: decode, reset-enable, output enables and latches
`include "bitio_map.svh"
module bit_io_port (
  input logic clk,
  input logic sys_rst,
  input logic [`ADDR_W-1:0] bit_addr,
  input logic write_pulse,
  input logic serial_write_bit,
  input logic port_match_select,
  input logic [`BASE_W-1:0] base_addr,
  input logic port_enable,
  input logic input_only,
  input logic pol_high,
  input logic pol_low,
  input logic [`PORT_BITS-1:0] port_in,
  output logic base_address_match,
  output logic [1:0] block_read_sel,
  output logic block_read_bit,
  output logic [`PORT_BITS-1:0] latch_q,
  output logic [1:0] oe_q,
  output logic rst_en_q,
  output logic [1:0] output_driver_enable,
  output logic [`PORT_BITS-1:0] pin_oe
);
  bitio_pkg::port_state_t s_r, s_nxt;
  logic [`DISP_MSB:0] disp;
  logic [`BITSEL_MSB:0] sel;
  logic blk_area, rsten_wr, clr_req, drive_h, drive_l;
  logic high_block_read_select_n, low_block_read_select_n;
  logic port_direction_clear_n;
  logic [1:0] block_write_select;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  assign base_address_match = port_enable &&
    bit_addr[`BASE_MSB:`BASE_LSB] == base_addr; // see (R20)
  assign disp = bit_addr[`DISP_MSB:0];
  assign sel = bit_addr[`BITSEL_MSB:0];
  assign blk_area = port_match_select && bit_addr[`A10_BIT];
  assign high_block_read_select_n =
    !(blk_area && !bit_addr[`A11_BIT]); // see (R17)
  assign low_block_read_select_n =
    !(blk_area && bit_addr[`A11_BIT]); // see (R17)
  assign block_write_select = {!high_block_read_select_n && write_pulse,
    !low_block_read_select_n && write_pulse}; // see (R18)
  assign rsten_wr = port_match_select && disp == `DISP_RESET_EN &&
    write_pulse;
  assign clr_req = port_match_select && disp == `DISP_CLEAR &&
    write_pulse && !serial_write_bit; // see (R03)
  // Hardware reset clears unconditionally, software only when enabled
  assign port_direction_clear_n =
    !(sys_rst || (clr_req && s_r.rst_en)); // see (R02) see (R04)
  assign block_read_sel = {!high_block_read_select_n,
    !low_block_read_select_n};
  assign block_read_bit = (block_read_sel[1] &&
    port_in[{1'b1, sel}]) || (block_read_sel[0] &&
    port_in[{1'b0, sel}]); // see (R10)

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    for (int b = 0; b < 2; b++) begin
      if (block_write_select[b]) begin
        s_nxt.oe[b] = 1'b1; // see (R06) see (R05)
        s_nxt.latch[{b[0], sel}] = serial_write_bit; // see (R11)
      end
    end
    if (rsten_wr) begin
      s_nxt.rst_en = serial_write_bit; // see (R01)
    end
    // Displacement 1E aliases a low-block bit; the clear wins over the set
    if (!port_direction_clear_n) begin
      s_nxt.oe = 2'h0; // see (R08) see (R05)
    end
    if (sys_rst) begin
      s_nxt.rst_en = 1'b0; // see (R04)
      s_nxt.latch = '0;
    end
    drive_h = s_nxt.oe[1] && !input_only; // see (R09)
    drive_l = s_nxt.oe[0] && !input_only; // see (R09)
    s_nxt.drv_en = {drive_h ^ pol_high, drive_l ^ pol_low}; // see (R07)
    s_nxt.pin_oe = {{`BLOCK_BITS{drive_h}},
      {`BLOCK_BITS{drive_l}}}; // see (R12)
  end

  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  assign latch_q = s_r.latch;
  assign oe_q = s_r.oe;
  assign rst_en_q = s_r.rst_en;
  assign output_driver_enable = s_r.drv_en;
  assign pin_oe = s_r.pin_oe;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_oe_set_write: assert property (@(posedge clk) disable iff (sys_rst) // see (R06)
    block_write_select[1] |=> s_r.oe[1])
    else $error("high block write did not enable outputs");
  a_clear_kills_oe: assert property (@(posedge clk) disable iff (sys_rst) // see (R08)
    !port_direction_clear_n |=> s_r.oe == 2'h0)
    else $error("port clear left an output enabled");
  a_clear_blocked: assert property (@(posedge clk) disable iff (sys_rst) // see (R02)
    clr_req && !s_r.rst_en |=> s_r.oe[1] == $past(s_r.oe[1]))
    else $error("clear passed with reset-enable low");
  a_rsten_clear: assert property (@(posedge clk) disable iff (sys_rst) // see (R01)
    rsten_wr |=> s_r.rst_en == $past(serial_write_bit))
    else $error("reset-enable latch did not take the write bit");
  a_input_only: assert property (@(posedge clk) disable iff (sys_rst) // see (R09)
    input_only |=> s_r.pin_oe == '0)
    else $error("input-only port drives outputs");
  a_drv_polarity: assert property (@(posedge clk) disable iff (sys_rst) // see (R07)
    1'b1 |=> s_r.drv_en[1] ==
      ((s_r.oe[1] && !$past(input_only)) ^ $past(pol_high)))
    else $error("driver enable polarity wrong");
  a_latch_write: assert property (@(posedge clk) disable iff (sys_rst) // see (R11)
    block_write_select[0] |=>
      s_r.latch[{1'b0, $past(sel)}] == $past(serial_write_bit))
    else $error("output latch bit not written");
  a_drive_gated: assert property (@(posedge clk) disable iff (sys_rst) // see (R12)
    s_r.pin_oe[0] |-> s_r.oe[0] && s_r.drv_en[0] != $past(pol_low))
    else $error("pins driven without block enable");
  c_sw_clear: cover property (@(posedge clk) disable iff (sys_rst)
    clr_req && s_r.rst_en && s_r.oe != 2'h0);
endmodule

// ==== sim/bit_bus_host.sv ====
// Host model for the bit-serial I/O bus side of the ports
`include "bitio_map.svh"
module bit_bus_host (
  input logic clk,
  output logic [`ADDR_W-1:0] bit_addr,
  output logic bit_write_strobe_n,
  output logic serial_write_bit,
  input logic serial_read_bit,
  input logic serial_read_en
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    bit_addr = '0;
    bit_write_strobe_n = 1'b1;
    serial_write_bit = 1'b0;
  end

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Address and data stand three cycles either side of each strobe edge
  task automatic write_bit(input logic [`ADDR_W-1:0] a, input logic b);
    @(posedge clk);
    bit_addr <= a;
    serial_write_bit <= b;
    repeat (3) @(posedge clk);
    bit_write_strobe_n <= 1'b0;
    repeat (4) @(posedge clk);
    bit_write_strobe_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Released data shows the inverse so a stale bit cannot pass
    serial_write_bit <= ~b;
  endtask

  task automatic read_bit(input logic [`ADDR_W-1:0] a, output logic b,
      output logic en);
    @(posedge clk);
    bit_addr <= a;
    repeat (4) @(posedge clk);
    @(negedge clk);
    b = serial_read_bit;
    en = serial_read_en;
  endtask
endmodule

// ==== sim/test_buffered_bit_io_ports.sv ====
// Self-checking bench for the buffered bit I/O ports
`include "bitio_map.svh"
module test_buffered_bit_io_ports;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [5:0] B0 = 6'h05;
  localparam logic [5:0] B1 = 6'h0a;
  localparam logic [5:0] B2 = 6'h0f;
  localparam logic [7:0] C1 = `OFF_CFG0 + `OFF_STEP;
  localparam logic [7:0] C2 = C1 + `OFF_STEP;
  localparam logic [7:0] L2 = `OFF_LATCH0 + `OFF_STEP + `OFF_STEP;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [47:0] port_in = '0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = '0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic serial_read_bit;
  logic serial_read_en;
  logic [`ADDR_W-1:0] bit_addr;
  logic bit_write_strobe_n;
  logic serial_write_bit;
  logic [47:0] port_out;
  logic [47:0] pin_oe;
  logic [5:0] output_driver_enable;
  int n_errors = 0;
  int checks_done = 0;
  logic [5:0] fb [6] = '{B0, B1, B2, B1, B0, B2};
  logic [4:0] fi [6] = '{5'h1f, 5'h1f, 5'h1f, 5'h11, 5'h00, 5'h11};
  logic fv [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};

  buffered_bit_io_ports DUT (
    .clk(clk), .sys_rst(sys_rst), .bit_addr(bit_addr),
    .bit_write_strobe_n(bit_write_strobe_n),
    .serial_write_bit(serial_write_bit), .port_in(port_in),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .serial_read_bit(serial_read_bit), .serial_read_en(serial_read_en),
    .port_out(port_out), .pin_oe(pin_oe),
    .output_driver_enable(output_driver_enable)
  );

  bit_bus_host host (
    .clk(clk), .bit_addr(bit_addr),
    .bit_write_strobe_n(bit_write_strobe_n),
    .serial_write_bit(serial_write_bit),
    .serial_read_bit(serial_read_bit), .serial_read_en(serial_read_en)
  );

  initial begin
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [47:0] e,
      input logic [47:0] s);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // Values that stand at the edge are taken in the preceding low phase
  task automatic bus_cycle(input logic [7:0] a, input logic w,
      input logic [31:0] wd, output logic [31:0] rd);
    logic r;
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= `HSIZE_WORD;
    do begin
      @(negedge clk);
      r = hreadyout;
      @(posedge clk);
    end while (r !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(negedge clk);
      r = hreadyout;
      rd = hrdata;
      @(posedge clk);
    end while (r !== 1'b1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus_cycle(a, 1'b1, d, x);
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a,
      input logic [31:0] e);
    logic [31:0] v;
    bus_cycle(a, 1'b0, 32'h0, v);
    chk(n, 48'(e), 48'(v));
    chk("hresp", 48'h0, 48'(hresp));
  endtask

  // Read data is only judged where the line is expected to be driven
  task automatic io_chk(input string n, input logic [11:0] a,
      input logic eb, input logic ee);
    logic b;
    logic en;
    host.read_bit(a, b, en);
    chk(n, 48'(ee), 48'(en));
    if (ee) begin
      chk(n, 48'(eb), 48'(b));
    end
  endtask

  function automatic logic [11:0] io_a(input logic [5:0] bs,
      input logic hi, input logic [2:0] b);
    return {bs, 1'b0, 1'b1, ~hi, b};
  endfunction

  function automatic logic [11:0] fl_a(input logic [5:0] bs,
      input logic [4:0] i);
    return {bs, i[4], 1'b0, i[3:0]};
  endfunction

  task automatic hw_reset;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    hw_reset();
    chk("pin_oe", 48'h0, pin_oe);
    chk("drv_en", 48'h0, 48'(output_driver_enable));
    for (int i = 0; i < 8; i++) begin
      rd_chk("reset_reg", 8'(4 * i), 32'h0);
    end
    wr(8'h40, 32'hffff_ffff);
    rd_chk("unmapped", 8'h40, 32'h0);
    wr(`OFF_CFG0, 32'h45);
    wr(C1, 32'h14a);
    wr(C2, 32'h0f);
    io_chk("disabled", io_a(B2, 1'b1, 3'h0), 1'b0, 1'b0);
    wr(C2, 32'hcf);
    rd_chk("cfg1", C1, 32'h14a);
    chk("drv_idle", 48'h08, 48'(output_driver_enable));
    host.write_bit(io_a(B0, 1'b0, 3'h3), 1'b1);
    rd_chk("latch0", `OFF_LATCH0, 32'h0008);
    rd_chk("status", `OFF_STATUS, 32'h08);
    chk("pin_oe0", 48'h00ff, 48'(pin_oe[15:0]));
    chk("out0", 48'h0008, 48'(port_out[15:0]));
    chk("drv_en", 48'h09, 48'(output_driver_enable));
    @(posedge clk);
    port_in <= 48'h0000_0000_a500;
    for (int i = 0; i < 8; i++) begin
      io_chk("in_bit", io_a(B0, 1'b1, 3'(i)), 1'(8'ha5 >> i), 1'b1);
    end
    rd_chk("read_no_oe", `OFF_STATUS, 32'h08);
    // Clear sequence: blocked, enabled, non-zero data, then real clear
    host.write_bit(io_a(B0, 1'b1, 3'h0), 1'b1);
    host.write_bit({B0, `DISP_CLEAR}, 1'b0);
    rd_chk("blocked", `OFF_STATUS, 32'h18);
    host.write_bit({B0, `DISP_RESET_EN}, 1'b1);
    rd_chk("rst_en", `OFF_STATUS, 32'h19);
    host.write_bit({B0, `DISP_CLEAR}, 1'b1);
    rd_chk("clr_one", `OFF_STATUS, 32'h19);
    host.write_bit({B0, `DISP_CLEAR}, 1'b0);
    rd_chk("cleared", `OFF_STATUS, 32'h01);
    chk("pin_oe0", 48'h0, 48'(pin_oe[15:0]));
    chk("drv_en", 48'h08, 48'(output_driver_enable));
    rd_chk("latch0", `OFF_LATCH0, 32'h0108);
    host.write_bit(io_a(B0, 1'b0, 3'h2), 1'b1);
    rd_chk("rewrite", `OFF_STATUS, 32'h09);
    chk("pin_oe0", 48'h00ff, 48'(pin_oe[15:0]));
    host.write_bit(io_a(B1, 1'b1, 3'h7), 1'b1);
    chk("drv_low", 48'h01, 48'(output_driver_enable));
    chk("pin_oe1", 48'hff00, 48'(pin_oe[31:16]));
    chk("out1", 48'h8000, 48'(port_out[31:16]));
    host.write_bit(io_a(B2, 1'b0, 3'h1), 1'b1);
    chk("pin_oe2", 48'h0, 48'(pin_oe[47:32]));
    chk("drv_en", 48'h01, 48'(output_driver_enable));
    chk("out2", 48'h0002, 48'(port_out[47:32]));
    // Low-block polarity set on port 1: its idle low enable turns high
    wr(C1, 32'h34a);
    repeat (2) @(posedge clk);
    chk("drv_pol_l", 48'h05, 48'(output_driver_enable));
    rd_chk("status", `OFF_STATUS, 32'hc9);
    rd_chk("latch2", L2, 32'h0002);
    for (int i = 0; i < 4; i++) begin
      host.write_bit(fl_a(fb[i], fi[i]), fv[i]);
    end
    for (int i = 0; i < 6; i++) begin
      io_chk("flag", fl_a(fb[i], fi[i]), fv[i], 1'b1);
    end
    // Two ports on one base must both stay silent
    wr(C2, 32'hc5);
    io_chk("dup_rd", io_a(B0, 1'b1, 3'h0), 1'b0, 1'b0);
    host.write_bit(io_a(B0, 1'b0, 3'h5), 1'b1);
    rd_chk("dup_wr", `OFF_LATCH0, 32'h010c);
    wr(C2, 32'hcf);
    hw_reset();
    rd_chk("rst_status", `OFF_STATUS, 32'h0);
    rd_chk("rst_latch", `OFF_LATCH0, 32'h0);
    chk("rst_pin_oe", 48'h0, pin_oe);
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
endmodule
